// ---- src/dac_port_pkg.sv ----
package dac_port_pkg;
    // ************************************************************
    // sample and control word widths
    // ************************************************************
    localparam int SAMPLE_W = 10;
    localparam int CW_W = 8;
    localparam int GAIN_W = 4;

    // control field positions on the channel A pins
    localparam int PIN_PD = 9;
    localparam int PIN_GAIN_HI = 5;
    localparam int PIN_GAIN_LO = 2;

    // field positions inside the latched control word
    localparam int CW_PD = 7;
    localparam int CW_EN = 6;
    localparam int CW_F2 = 5;
    localparam int CW_F1 = 4;
    localparam int CW_GAIN_HI = 3;

    // no interpolation, zero trim, converter on
    localparam logic [7:0] CW_RESET = 8'h40;

    // interpolation mode codes
    localparam logic [1:0] INTERP_NONE = 2'h0;
    localparam logic [1:0] INTERP_2X = 2'h1;
    localparam logic [1:0] INTERP_4X = 2'h2;

    // trim step in hundredths of a dB
    localparam logic [7:0] GAIN_STEP_CDB = 8'h05;

    // ************************************************************
    // bus map
    // ************************************************************
    localparam int ADDR_W = 12;
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam logic [11:0] ADDR_SAMPLE = 12'h008;
    localparam int HTRANS_ACTIVE_BIT = 1;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam int STATUS_USED_W = 15;
    localparam int SAMPLE_HALF_W = 16;
endpackage : dac_port_pkg

// ---- src/pin_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // one two-stage synchroniser per pin; only stage two is read
    for (genvar g = 0; g < W; g++) begin : g_bit
        always_ff @(posedge i_clk or negedge i_reset_n) begin
            if (!i_reset_n) begin
                meta_q[g] <= RST[g];
                sync_q[g] <= RST[g];
            end else begin
                meta_q[g] <= i_async[g];
                sync_q[g] <= meta_q[g];
            end
        end
    end

    assign o_sync = sync_q;
endmodule : pin_sync
`default_nettype wire

// ---- src/dac_input_port.sv ----
// How it works
// RULE_01 - power-down bit set forces full power-down, whatever enable says.
// RULE_02 - power-down clear: enable 0 gives standby, enable 1 normal run.
// RULE_03 - second filter bit clear: first bit picks none (0) or 2x (1).
// RULE_04 - second filter bit picks 4x; the source must set the first too.
// RULE_05 - gain trim is the 4-bit field on channel A bits 5..2, 5 the MSB.
// RULE_06 - power-down on bit 9, enable 8, second filter 7, first 6, trim 5..2.
// RULE_07 - word on channel A, low strobe pulsed; its falling edge takes it.
// RULE_08 - interleave high: both channels are taken from channel A's port.
// RULE_09 - interleave low: A latched on clock rise, B on clock fall.
// RULE_10 - each channel takes a 10-bit sample, bit 9 the MSB, on its own bus.
// RULE_11 - the control word is eight bits: gain, interpolation and mode.
// RULE_12 - trim spans -0.4 dB to 0.35 dB in 0.05 dB steps.
// RULE_13 - after reset: no interpolation, zero trim, converter running.
// RULE_14 - samples latched on a rising edge reach the output on the next.
// RULE_15 - control write: bits 1 and 0 ignored, sample path held still.
// RULE_16 - in interleave mode channel B's bus is ignored.
//
// Our own choices: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module dac_input_port (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_diff_clock_in_pos,
    input wire logic i_diff_clock_in_neg,
    input wire logic [9:0] i_chan_a_data,
    input wire logic [9:0] i_chan_b_data,
    input wire logic i_control_write_strobe_n,
    input wire logic i_interleave_select,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic o_hreadyout,
    output logic o_hresp,
    output logic [31:0] o_hrdata,
    output logic o_clock_out,
    output logic [9:0] o_sample_a,
    output logic [9:0] o_sample_b,
    output logic o_power_down,
    output logic o_standby,
    output logic o_converter_on,
    output logic [1:0] o_interp_mode,
    output logic o_filter_illegal,
    output logic [3:0] o_gain_trim,
    output logic signed [7:0] o_gain_trim_cdb
);
    localparam int SW = dac_port_pkg::SAMPLE_W;
    localparam int NSYNC = 2 * SW + 4;
    localparam logic [NSYNC-1:0] SYNC_RST = {4'h4, {(2 * SW){1'b0}}};

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    logic [NSYNC-1:0] pins_s;
    logic [SW-1:0] a_s;
    logic [SW-1:0] b_s;
    logic cw_n_s;
    logic ilv_s;
    logic pos_s;
    logic neg_s;

    // strobe resets high so release does not look like a write
    pin_sync #(
        .W(NSYNC),
        .RST(SYNC_RST)
    ) u_sync (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_async({i_interleave_select, i_control_write_strobe_n,
                  i_diff_clock_in_pos, i_diff_clock_in_neg,
                  i_chan_b_data, i_chan_a_data}),
        .o_sync(pins_s)
    );

    assign a_s = pins_s[SW-1:0];
    assign b_s = pins_s[2*SW-1:SW];
    assign neg_s = pins_s[2*SW];
    assign pos_s = pins_s[2*SW+1];
    assign cw_n_s = pins_s[2*SW+2];
    assign ilv_s = pins_s[2*SW+3];

    // ************************************************************
    // clock receiver and edge detection
    // ************************************************************
    logic clk_lvl_q;
    logic clk_lvl_d;
    logic cw_prev_q;
    wire clk_rise = clk_lvl_d & ~clk_lvl_q;
    wire clk_fall = ~clk_lvl_d & clk_lvl_q;
    wire cw_fall = ~cw_n_s & cw_prev_q;

    // equal legs keep the old level, a cheap form of hysteresis
    assign clk_lvl_d = (pos_s ^ neg_s) ? pos_s : clk_lvl_q;

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            clk_lvl_q <= 1'b0;
            cw_prev_q <= 1'b1;
        end else begin
            clk_lvl_q <= clk_lvl_d;
            cw_prev_q <= cw_n_s;
        end
    end

    assign o_clock_out = clk_lvl_q;

    // ************************************************************
    // bus slave
    // ************************************************************
    logic wr_pend_q;
    logic [dac_port_pkg::ADDR_W-1:0] wr_addr_q;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic [31:0] status_w;
    logic [31:0] sample_w;
    logic [7:0] ctrl_q;

    wire [dac_port_pkg::ADDR_W-1:0] addr_lo =
        i_haddr[dac_port_pkg::ADDR_W-1:0];
    wire ahb_take = i_hsel & i_hready
        & i_htrans[dac_port_pkg::HTRANS_ACTIVE_BIT]
        & (i_hsize == dac_port_pkg::HSIZE_WORD);
    wire sw_wr = wr_pend_q & (wr_addr_q == dac_port_pkg::ADDR_CTRL);

    assign status_w = {{(32 - dac_port_pkg::STATUS_USED_W){1'b0}},
        ilv_s, o_filter_illegal, o_converter_on, o_standby,
        o_power_down, o_interp_mode, ctrl_q};
    assign sample_w = {{(dac_port_pkg::SAMPLE_HALF_W - SW){1'b0}},
        o_sample_b,
        {(dac_port_pkg::SAMPLE_HALF_W - SW){1'b0}}, o_sample_a};
    // unmapped words read as zero, still OKAY
    assign rdata_d =
        (addr_lo == dac_port_pkg::ADDR_CTRL) ? {24'h000000, ctrl_q} :
        (addr_lo == dac_port_pkg::ADDR_STATUS) ? status_w :
        (addr_lo == dac_port_pkg::ADDR_SAMPLE) ? sample_w : 32'h00000000;

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= '0;
            rdata_q <= 32'h00000000;
        end else begin
            wr_pend_q <= ahb_take & i_hwrite;
            wr_addr_q <= addr_lo;
            if (ahb_take && !i_hwrite) begin
                rdata_q <= rdata_d;
            end
        end
    end

    // zero wait states: every transfer finishes in its data phase
    assign o_hreadyout = 1'b1;
    assign o_hresp = 1'b0;
    assign o_hrdata = rdata_q;

    // ************************************************************
    // control word capture and decode
    // ************************************************************
    // bits 1 and 0 of the port never reach the word [RULE_15]
    wire [7:0] pin_word = a_s[dac_port_pkg::PIN_PD:dac_port_pkg::PIN_GAIN_LO];
    logic [7:0] ctrl_d;

    // a pin strobe wins over a bus write in the same cycle
    assign ctrl_d = cw_fall ? pin_word :                // [RULE_07] [RULE_06]
                    sw_wr ? i_hwdata[7:0] : ctrl_q;    // [RULE_11]

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ctrl_q <= dac_port_pkg::CW_RESET;             // [RULE_13]
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    wire pd_bit = ctrl_q[dac_port_pkg::CW_PD];
    wire en_bit = ctrl_q[dac_port_pkg::CW_EN];
    wire f2_bit = ctrl_q[dac_port_pkg::CW_F2];
    wire f1_bit = ctrl_q[dac_port_pkg::CW_F1];

    assign o_power_down = pd_bit;                         // [RULE_01]
    assign o_standby = ~pd_bit & ~en_bit;                 // [RULE_02]
    assign o_converter_on = ~pd_bit & en_bit;             // [RULE_02]
    assign o_interp_mode = f2_bit ? dac_port_pkg::INTERP_4X :   // [RULE_04]
        (f1_bit ? dac_port_pkg::INTERP_2X :                    // [RULE_03]
                  dac_port_pkg::INTERP_NONE);
    // the source broke its side of the filter pairing
    assign o_filter_illegal = f2_bit & ~f1_bit;           // [RULE_04]
    assign o_gain_trim = ctrl_q[dac_port_pkg::CW_GAIN_HI:0];  // [RULE_05]
    // two's complement code times 0.05 dB: -8..7 spans -0.40..+0.35
    assign o_gain_trim_cdb = 8'(signed'({{4{o_gain_trim[3]}}, o_gain_trim})
        * signed'(dac_port_pkg::GAIN_STEP_CDB));          // [RULE_12]

    // ************************************************************
    // sample path
    // ************************************************************
    logic [SW-1:0] a_lat_q;
    logic [SW-1:0] b_lat_q;
    logic [SW-1:0] out_a_q;
    logic [SW-1:0] out_b_q;
    // a low strobe means channel A carries a control word
    wire cw_busy = ~cw_n_s;
    wire [SW-1:0] b_src = ilv_s ? a_s : b_s;              // [RULE_08] [RULE_16]
    wire take_a = clk_rise & ~cw_busy;                    // [RULE_09] [RULE_15]
    wire take_b = clk_fall & ~cw_busy;                    // [RULE_09] [RULE_15]

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            a_lat_q <= '0;
            b_lat_q <= '0;
        end else begin
            if (take_a) begin
                a_lat_q <= a_s;                           // [RULE_10]
            end
            if (take_b) begin
                b_lat_q <= b_src;                         // [RULE_10]
            end
        end
    end

    // converter update one rising edge after the latch
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            out_a_q <= '0;
            out_b_q <= '0;
        end else if (clk_rise) begin
            out_a_q <= a_lat_q;                           // [RULE_14]
            out_b_q <= b_lat_q;                           // [RULE_14]
        end
    end

    assign o_sample_a = out_a_q;
    assign o_sample_b = out_b_q;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_reset_n);

    sequence s_pin_write;
        cw_fall ##1 1'b1;
    endsequence

    sequence s_rise_latch;
        take_a ##1 1'b1;
    endsequence

    chk_pd_full_off: assert property (pd_bit |-> o_power_down // [RULE_01]
        && !o_converter_on && !o_standby)
        else $error("power-down bit did not force full power-down");

    chk_standby_mode: assert property ( // [RULE_02]
        (!pd_bit && !en_bit) |-> (o_standby && !o_converter_on))
        else $error("enable low did not give standby");

    chk_interp_2x: assert property ( // [RULE_03]
        (!f2_bit && f1_bit) |-> o_interp_mode == dac_port_pkg::INTERP_2X)
        else $error("first filter bit did not give 2x");

    chk_interp_4x: assert property ( // [RULE_04]
        f2_bit |-> o_interp_mode == dac_port_pkg::INTERP_4X)
        else $error("second filter bit did not give 4x");

    chk_word_capture: assert property (s_pin_write |-> // [RULE_07]
        ctrl_q == $past(a_s[dac_port_pkg::PIN_PD:dac_port_pkg::PIN_GAIN_LO]))
        else $error("control word not captured on strobe fall");

    chk_gain_field: assert property (s_pin_write |-> // [RULE_05]
        o_gain_trim == $past(
        a_s[dac_port_pkg::PIN_GAIN_HI:dac_port_pkg::PIN_GAIN_LO]))
        else $error("gain trim not taken from bits 5..2");

    chk_a_on_rise: assert property (s_rise_latch |-> // [RULE_09]
        a_lat_q == $past(a_s))
        else $error("channel A not latched on the clock rise");

    chk_cw_hold_samples: assert property (cw_busy |=> // [RULE_15]
        $stable(a_lat_q) && $stable(b_lat_q))
        else $error("sample latch moved during a control write");

    chk_ilv_b_from_a: assert property ( // [RULE_08]
        (take_b && ilv_s) |=> b_lat_q == $past(a_s))
        else $error("interleave did not take B from port A");

    chk_split_b_port: assert property ( // [RULE_09]
        (take_b && !ilv_s) |=> b_lat_q == $past(b_s))
        else $error("channel B not latched from its own bus");

    chk_out_next_edge: assert property ( // [RULE_14]
        clk_rise |=> o_sample_a == $past(a_lat_q)
        && o_sample_b == $past(b_lat_q))
        else $error("converter not updated on the rising edge");

    chk_out_waits: assert property ( // [RULE_14]
        !clk_rise |=> $stable(o_sample_a) && $stable(o_sample_b))
        else $error("converter changed between rising edges");

    chk_trim_scale: assert property ( // [RULE_12]
        o_gain_trim_cdb >= -8'sd40 && o_gain_trim_cdb <= 8'sd35)
        else $error("gain trim out of its span");
endmodule : dac_input_port
`default_nettype wire

// ---- tb/dac_source_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module dac_source_model (
    input wire logic [9:0] i_next_a,
    input wire logic [9:0] i_next_b,
    input wire logic i_interleave,
    output logic o_clk_pos,
    output logic o_clk_neg,
    output logic [9:0] o_chan_a,
    output logic [9:0] o_chan_b,
    output logic o_strobe_n,
    output logic o_interleave
);
    logic busy_q;
    assign o_clk_neg = ~o_clk_pos;
    assign o_interleave = i_interleave;
    initial begin
        busy_q = 1'b0;
        o_chan_a = 10'h000;
        o_chan_b = 10'h000;
        o_strobe_n = 1'b1;
        o_clk_pos = 1'b0;
        #13;
        forever #200 o_clk_pos = ~o_clk_pos;
    end
    // data moves midway between link edges; the slot not latched carries
    // the inverse so a wrong-edge capture shows up
    always @(o_clk_pos) begin
        #100;
        if (!busy_q) begin
            if (o_clk_pos) begin
                o_chan_a = i_interleave ? i_next_b : ~i_next_a;
                o_chan_b = i_interleave ? ~i_next_b : i_next_b;
            end else begin
                o_chan_a = i_next_a;
                o_chan_b = ~i_next_b;
            end
        end
    end
    task automatic write_word(input logic [7:0] w, input logic [1:0] lo);
        #7 busy_q = 1'b1;
        o_chan_a = {w, lo};
        #200 o_strobe_n = 1'b0;
        #200 o_strobe_n = 1'b1;
        #200 busy_q = 1'b0;
    endtask : write_word
endmodule : dac_source_model
`default_nettype wire

// ---- tb/dual_dac_input_port_ctrl_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module dual_dac_input_port_ctrl_tb;
    logic i_clk, i_reset_n, i_hsel, i_hwrite, ide_sel;
    logic [31:0] i_haddr, i_hwdata, hrdata, r;
    logic [1:0] i_htrans;
    logic [2:0] i_hsize;
    logic [9:0] next_a, next_b, sample_a, sample_b, chan_a, chan_b;
    logic [7:0] w;
    logic hreadyout, hresp, clock_out, power_down, standby, converter_on;
    logic filter_illegal, clk_pos, clk_neg, strobe_n, interleave_select;
    logic [1:0] interp_mode;
    logic [3:0] gain_trim;
    logic signed [7:0] gain_trim_cdb;
    int errors = 0;
    int n_tests = 0;
    int seed = 7;
    int cyc = 0;
    wire logic [17:0] outs = {power_down, standby, converter_on, interp_mode,
        filter_illegal, gain_trim, gain_trim_cdb};

    dac_source_model src (.i_next_a(next_a), .i_next_b(next_b),
        .i_interleave(ide_sel), .o_clk_pos(clk_pos), .o_clk_neg(clk_neg),
        .o_chan_a(chan_a), .o_chan_b(chan_b), .o_strobe_n(strobe_n),
        .o_interleave(interleave_select));
    dac_input_port dut (.i_clk(i_clk), .i_reset_n(i_reset_n),
        .i_diff_clock_in_pos(clk_pos), .i_diff_clock_in_neg(clk_neg),
        .i_chan_a_data(chan_a), .i_chan_b_data(chan_b),
        .i_control_write_strobe_n(strobe_n), .i_interleave_select(interleave_select),
        .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans),
        .i_hwrite(i_hwrite), .i_hsize(i_hsize), .i_hwdata(i_hwdata),
        .i_hready(hreadyout), .o_hreadyout(hreadyout), .o_hresp(hresp),
        .o_hrdata(hrdata), .o_clock_out(clock_out), .o_sample_a(sample_a),
        .o_sample_b(sample_b), .o_power_down(power_down),
        .o_standby(standby), .o_converter_on(converter_on),
        .o_interp_mode(interp_mode), .o_filter_illegal(filter_illegal),
        .o_gain_trim(gain_trim), .o_gain_trim_cdb(gain_trim_cdb));

    initial i_clk = 1'b0;
    always #25 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            test_done();
        end
    end
    // ************************************************************
    // checking and bus helpers
    // ************************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic ahb_xfer(input logic wr, input logic [31:0] addr,
                            input logic [31:0] wdata, output logic [31:0] rd);
        @(posedge i_clk);
        i_hsel <= 1'b1;
        i_haddr <= addr;
        i_htrans <= 2'h2;
        i_hwrite <= wr;
        i_hsize <= dac_port_pkg::HSIZE_WORD;
        do @(posedge i_clk); while (hreadyout !== 1'b1);
        i_hsel <= 1'b0;
        i_htrans <= 2'h0;
        i_hwdata <= wdata;
        do @(posedge i_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
        check(32'(hresp), 32'h0);
    endtask : ahb_xfer
    function automatic logic [17:0] exp_out(input logic [7:0] c);
        logic [1:0] m;
        m = c[5] ? dac_port_pkg::INTERP_4X
            : (c[4] ? dac_port_pkg::INTERP_2X : dac_port_pkg::INTERP_NONE);
        return {c[7], ~c[7] & ~c[6], ~c[7] & c[6], m, c[5] & ~c[4], c[3:0],
            8'(5 * $signed(c[3:0]))};
    endfunction : exp_out
    task automatic check_word(input logic [7:0] c);
        logic [17:0] o;
        o = exp_out(c);
        ahb_xfer(1'b0, 32'(dac_port_pkg::ADDR_STATUS), 32'h0, r);
        check(r, {17'h0, ide_sel, o[12], o[15], o[16], o[17],
            o[14:13], c});
        check(32'(outs), 32'(o));
    endtask : check_word
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : test_done
    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        i_reset_n = 1'b0;
        i_hsel = 1'b0;
        i_haddr = 32'h0;
        i_htrans = 2'h0;
        i_hwrite = 1'b0;
        i_hsize = 3'h0;
        i_hwdata = 32'h0;
        next_a = 10'h000;
        next_b = 10'h000;
        ide_sel = 1'b0;
        repeat (8) @(posedge i_clk);
        i_reset_n <= 1'b1;
        check_word(dac_port_pkg::CW_RESET);
        $display("test reset_defaults done");
        // every power mode crossed with every legal filter setting
        for (int i = 0; i < 12; i++) begin
            w = 8'($random(seed));
            w[7:6] = 2'(i);
            w[5:4] = (i < 4) ? 2'h0 : ((i < 8) ? 2'h1 : 2'h3);
            src.write_word(w, 2'($random(seed)));
            check_word(w);
        end
        $display("test strobe_words done");
        w = 8'h78;
        ahb_xfer(1'b1, 32'(dac_port_pkg::ADDR_CTRL), {24'h0, w}, r);
        ahb_xfer(1'b1, 32'(dac_port_pkg::ADDR_STATUS), 32'hFFFF_FFFF, r);
        ahb_xfer(1'b0, 32'(dac_port_pkg::ADDR_CTRL), 32'h0, r);
        check(r, {24'h0, w});
        check_word(w);
        // a pairing the source must not send still decodes as 4x, flagged
        w = 8'h27;
        ahb_xfer(1'b1, 32'(dac_port_pkg::ADDR_CTRL), {24'h0, w}, r);
        check_word(w);
        ahb_xfer(1'b0, 32'h0000_0010, 32'h0, r);
        check(r, 32'h0);
        $display("test bus_access done");
        // extreme codes first, then random ones, in both port modes
        for (int i = 0; i < 10; i++) begin
            ide_sel <= (i >= 5);
            next_a <= (i % 5 == 0) ? {10{i == 0}} : 10'($random(seed));
            next_b <= (i % 5 == 0) ? {10{i == 5}} : 10'($random(seed));
            repeat (3) @(posedge clk_pos);
            // the recovered clock lags the pins by three system clocks
            check(32'(clock_out), 32'h0);
            repeat (4) @(posedge i_clk);
            check(32'(clock_out), 32'h1);
            repeat (2) @(posedge i_clk);
            check({12'h0, sample_b, sample_a},
                {12'h0, next_b, next_a});
            ahb_xfer(1'b0, 32'(dac_port_pkg::ADDR_SAMPLE), 32'h0, r);
            check(r, {6'h0, next_b, 6'h0, next_a});
        end
        check_word(w);
        $display("test sample_ports done");
        test_done();
    end
endmodule : dual_dac_input_port_ctrl_tb
`default_nettype wire
